// ### design/motion_setpoint_probe_params.v
// Parameter bank of a servo drive: homing speeds and acceleration, cyclic target
// offsets with feedforward, and the two-probe capture control.
// Assumes object writes arrive as one-cycle strobes with index, sub-index and data
// from the fieldbus stack on the same clock; probe pins and encoder index are async.
`default_nettype none
`include "motion_params_regs.vh"
module motion_setpoint_probe_params (
  input wire clk, // 20 MHz control clock
  input wire rstn, // Synchronous reset, active low
  input wire obj_wr, // Object write strobe
  input wire [15:0] obj_index, // Object index
  input wire [7:0] obj_sub, // Object sub-index
  input wire [31:0] obj_wdata, // Write data, narrow objects in low bits
  input wire [15:0] rd_index, // Object index to read
  input wire [7:0] rd_sub, // Sub-index to read
  output reg [31:0] rd_data_r, // Read data, one cycle after rd_index
  output reg rd_valid_r, // Read index mapped
  input wire [2:0] op_mode, // Active operating mode
  input wire homing_enable, // Homing start from control word
  input wire halt, // Halt request
  input wire [2:0] halt_option, // Halt option code
  input wire decel_point_hit, // Deceleration point detected
  input wire decel_done, // Ramp-down finished
  input wire home_in, // Home signal, same clock domain
  input wire [1:0] speed_ff_src, // Speed feedforward source
  input wire [1:0] torque_ff_src, // Torque feedforward source
  input wire [31:0] target_position, // Commanded target position
  input wire [31:0] target_velocity, // Commanded target velocity
  input wire [15:0] target_torque, // Commanded target torque
  input wire [31:0] actual_position, // Position for probe capture
  input wire probe_one_input, // Probe one pin, async
  input wire probe_two_input, // Probe two pin, async
  input wire encoder_index, // Encoder index pulse, async
  output reg [31:0] eff_position_r, // Effective target position
  output reg [31:0] eff_velocity_r, // Effective target speed
  output reg [15:0] eff_torque_r, // Effective target torque
  output reg [31:0] speed_ff_r, // Speed feedforward
  output reg speed_ff_valid_r, // Speed feedforward in use
  output reg [15:0] torque_ff_r, // Torque feedforward
  output reg torque_ff_valid_r, // Torque feedforward in use
  output reg [31:0] homing_speed_r, // Active homing speed
  output reg [31:0] active_accel_r, // Homing acceleration in effect
  output reg home_qual_r, // Home input as seen by the homing logic
  output reg halt_decel_r, // Halt ramp with homing accel active
  output reg [15:0] probe_status_r, // Probe status word
  output reg [31:0] probe1_rise_pos_r, // Probe one rising capture
  output reg [31:0] probe1_fall_pos_r, // Probe one falling capture
  output reg [31:0] probe2_rise_pos_r, // Probe two rising capture
  output reg [31:0] probe2_fall_pos_r // Probe two falling capture
);
  // ****************************************
  // Helpers
  // ****************************************
  // Clamp a signed 16-bit torque value to the documented span
  function [15:0] clamp_torque;
    input [15:0] v;
    begin
      if ($signed(v) > $signed(`TORQUE_OFS_MAX))
        clamp_torque = `TORQUE_OFS_MAX;
      else if ($signed(v) < $signed(`TORQUE_OFS_MIN))
        clamp_torque = `TORQUE_OFS_MIN;
      else
        clamp_torque = v;
    end
  endfunction

  // Object select
  function hit;
    input [15:0] idx;
    input [15:0] want;
    begin
      hit = (idx == want);
    end
  endfunction

  // ****************************************
  // Parameter storage
  // ****************************************
  reg [31:0] switch_speed_r;
  reg [31:0] zero_speed_r;
  reg [31:0] homing_accel_r;
  reg [31:0] position_offset_r;
  reg [31:0] velocity_offset_r;
  reg [15:0] torque_offset_r;
  reg [15:0] probe_control_r;
  reg homing_en_d_r;
  reg decel_phase_r;
  reg seek_zero_r;

  // Object writes with range handling
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      switch_speed_r <= `RST_SWITCH_SPEED;
      zero_speed_r <= `RST_ZERO_SPEED;
      homing_accel_r <= `RST_HOMING_ACCEL;
      position_offset_r <= `RST_OFFSET32;
      velocity_offset_r <= `RST_OFFSET32;
      torque_offset_r <= `RST_OFFSET16;
      probe_control_r <= `RST_OFFSET16;
    end
    else if (obj_wr)
    begin
      if (hit(obj_index, `IDX_HOMING_SPEEDS) && obj_sub == `SUB_SWITCH_SPEED)
        switch_speed_r <= obj_wdata;
      if (hit(obj_index, `IDX_HOMING_SPEEDS) && obj_sub == `SUB_ZERO_SPEED
          && obj_wdata >= `MIN_ZERO_SPEED)
        zero_speed_r <= obj_wdata;
      if (hit(obj_index, `IDX_HOMING_ACCEL))
        homing_accel_r <= (obj_wdata == 32'h00000000) ? 32'h00000001 : obj_wdata;
      if (hit(obj_index, `IDX_POSITION_OFFSET))
        position_offset_r <= obj_wdata;
      if (hit(obj_index, `IDX_VELOCITY_OFFSET))
        velocity_offset_r <= obj_wdata;
      if (hit(obj_index, `IDX_TORQUE_OFFSET))
        torque_offset_r <= clamp_torque(obj_wdata[15:0]);
      if (hit(obj_index, `IDX_PROBE_CONTROL))
        probe_control_r <= obj_wdata[15:0];
    end
  end

  // ****************************************
  // Homing support
  // ****************************************
  // Acceleration is taken on the rising edge of homing enable; deceleration masks home
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      homing_en_d_r <= 1'b0;
      active_accel_r <= `RST_HOMING_ACCEL;
      decel_phase_r <= 1'b0;
      seek_zero_r <= 1'b0;
      homing_speed_r <= `RST_SWITCH_SPEED;
      home_qual_r <= 1'b0;
      halt_decel_r <= 1'b0;
    end
    else
    begin
      homing_en_d_r <= homing_enable;
      if (homing_enable && !homing_en_d_r)
        active_accel_r <= homing_accel_r;
      if (!homing_enable)
      begin
        decel_phase_r <= 1'b0;
        seek_zero_r <= 1'b0;
      end
      else if (decel_point_hit && !seek_zero_r)
      begin
        decel_phase_r <= 1'b1;
        seek_zero_r <= 1'b1;
      end
      else if (decel_done)
        decel_phase_r <= 1'b0;
      homing_speed_r <= seek_zero_r ? zero_speed_r : switch_speed_r;
      if (!decel_phase_r)
        home_qual_r <= home_in;
      halt_decel_r <= (op_mode == `MODE_HOMING) && halt
                      && (halt_option == `HALT_OPT_HOMING_ACCEL);
    end
  end

  // ****************************************
  // Cyclic targets and feedforward
  // ****************************************
  // Offsets are summed only in their own mode; other modes pass the target through
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      eff_position_r <= 32'h00000000;
      eff_velocity_r <= 32'h00000000;
      eff_torque_r <= 16'h0000;
      speed_ff_r <= 32'h00000000;
      speed_ff_valid_r <= 1'b0;
      torque_ff_r <= 16'h0000;
      torque_ff_valid_r <= 1'b0;
    end
    else
    begin
      eff_position_r <= (op_mode == `MODE_POS) ?
                        target_position + position_offset_r : target_position;
      eff_velocity_r <= (op_mode == `MODE_VEL) ?
                        target_velocity + velocity_offset_r : target_velocity;
      eff_torque_r <= (op_mode == `MODE_TRQ) ?
                      target_torque + torque_offset_r : target_torque;
      speed_ff_valid_r <= (op_mode == `MODE_POS) && (speed_ff_src == `FF_SRC_BUS);
      speed_ff_r <= ((op_mode == `MODE_POS) && (speed_ff_src == `FF_SRC_BUS)) ?
                    velocity_offset_r : 32'h00000000;
      torque_ff_valid_r <= (op_mode == `MODE_POS) && (torque_ff_src == `FF_SRC_BUS);
      torque_ff_r <= ((op_mode == `MODE_POS) && (torque_ff_src == `FF_SRC_BUS)) ?
                     torque_offset_r : 16'h0000;
    end
  end

  // ****************************************
  // Probes
  // ****************************************
  wire p1_sync;
  wire p2_sync;
  wire idx_sync;
  wire [7:0] p1_status;
  wire [7:0] p2_status;

  pin_sync3 u_sync_p1 (.clk(clk), .rstn(rstn), .pin(probe_one_input), .level_r(p1_sync));
  pin_sync3 u_sync_p2 (.clk(clk), .rstn(rstn), .pin(probe_two_input), .level_r(p2_sync));
  pin_sync3 u_sync_ix (.clk(clk), .rstn(rstn), .pin(encoder_index), .level_r(idx_sync));

  probe_unit u_probe1 (
    .clk(clk),
    .rstn(rstn),
    .ctrl(probe_control_r[7:0]),
    .dig_in(p1_sync),
    .index_in(idx_sync),
    .position(actual_position),
    .status_r(p1_status),
    .rise_pos_r(probe1_rise_pos_r),
    .fall_pos_r(probe1_fall_pos_r)
  );

  probe_unit u_probe2 (
    .clk(clk),
    .rstn(rstn),
    .ctrl(probe_control_r[15:`PROBE_TWO_SHIFT]),
    .dig_in(p2_sync),
    .index_in(idx_sync),
    .position(actual_position),
    .status_r(p2_status),
    .rise_pos_r(probe2_rise_pos_r),
    .fall_pos_r(probe2_fall_pos_r)
  );

  // Status word, one byte per probe
  always @(posedge clk)
  begin
    if (!rstn)
      probe_status_r <= 16'h0000;
    else
      probe_status_r <= {p2_status, p1_status};
  end

  // ****************************************
  // Object read port
  // ****************************************
  // Registered read; unmapped index returns zero with valid low
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_data_r <= 32'h00000000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= 1'b1;
      case (rd_index)
        `IDX_HOMING_SPEEDS:
        begin
          if (rd_sub == `SUB_SWITCH_SPEED)
            rd_data_r <= switch_speed_r;
          else if (rd_sub == `SUB_ZERO_SPEED)
            rd_data_r <= zero_speed_r;
          else
          begin
            rd_data_r <= 32'h00000000;
            rd_valid_r <= 1'b0;
          end
        end
        `IDX_HOMING_ACCEL: rd_data_r <= homing_accel_r;
        `IDX_POSITION_OFFSET: rd_data_r <= position_offset_r;
        `IDX_VELOCITY_OFFSET: rd_data_r <= velocity_offset_r;
        `IDX_TORQUE_OFFSET: rd_data_r <= {{16{torque_offset_r[15]}}, torque_offset_r};
        `IDX_PROBE_CONTROL: rd_data_r <= {16'h0000, probe_control_r};
        `IDX_PROBE_STATUS: rd_data_r <= {16'h0000, probe_status_r};
        default:
        begin
          rd_data_r <= 32'h00000000;
          rd_valid_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // motion_setpoint_probe_params
`default_nettype wire

// ### design/motion_params_regs.vh
// Object indexes, field positions, reset values and constants of the motion parameter bank.
// Included by the top and probe design files of the bank, not by the synchroniser; holds definitions only.
`ifndef MOTION_PARAMS_REGS_VH
`define MOTION_PARAMS_REGS_VH
// ****************************************
// Object indexes (16-bit) and sub-indexes (8-bit)
// ****************************************
`define IDX_HOMING_SPEEDS 16'h6099
`define SUB_SWITCH_SPEED 8'h01
`define SUB_ZERO_SPEED 8'h02
`define IDX_HOMING_ACCEL 16'h609A
`define IDX_POSITION_OFFSET 16'h60B0
`define IDX_VELOCITY_OFFSET 16'h60B1
`define IDX_TORQUE_OFFSET 16'h60B2
`define IDX_PROBE_CONTROL 16'h60B8
`define IDX_PROBE_STATUS 16'h60B9
// ****************************************
// Reset values
// ****************************************
`define RST_SWITCH_SPEED 32'h001AAAAB
`define RST_ZERO_SPEED 32'h00000064
`define RST_HOMING_ACCEL 32'h00000064
`define RST_OFFSET32 32'h00000000
`define RST_OFFSET16 16'h0000
// ****************************************
// Limits and selector codes
// ****************************************
`define MIN_ZERO_SPEED 32'h0000000A
`define TORQUE_OFS_MAX 16'h1388
`define TORQUE_OFS_MIN 16'hEC78
`define FF_SRC_BUS 2'h2
`define HALT_OPT_HOMING_ACCEL 3'h2
// ****************************************
// Probe control word fields (probe two adds 8)
// ****************************************
`define PCW_ENABLE 0
`define PCW_CONTINUOUS 1
`define PCW_SOURCE 2
`define PCW_RISE_EN 4
`define PCW_FALL_EN 5
`define PROBE_TWO_SHIFT 8
// ****************************************
// Probe status fields (per byte)
// ****************************************
`define PSW_ENABLE 0
`define PSW_RISE_STORED 1
`define PSW_FALL_STORED 2
`define PSW_SOURCE 6
`define PSW_LEVEL 7
// ****************************************
// Operating modes
// ****************************************
`define MODE_HOMING 3'h1
`define MODE_POS 3'h2
`define MODE_VEL 3'h3
`define MODE_TRQ 3'h4
`endif

// ### design/pin_sync3.v
// Three-stage synchroniser with agreement filter for an asynchronous pin.
// Assumes the pin is quasi-static relative to clk.
`default_nettype none
module pin_sync3 (
  input wire clk, // System clock
  input wire rstn, // Synchronous reset, active low
  input wire pin, // Asynchronous input
  output reg level_r // Filtered level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // Shift chain; output follows only when stages two and three agree
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end
endmodule // pin_sync3
`default_nettype wire

// ### design/probe_unit.v
// One position-capture probe: trigger choice, edge detection and stored flags.
// Assumes synchronised trigger inputs and a control byte from the probe control word.
`default_nettype none
`include "motion_params_regs.vh"
module probe_unit (
  input wire clk, // System clock
  input wire rstn, // Synchronous reset, active low
  input wire [7:0] ctrl, // Control byte of this probe
  input wire dig_in, // Synchronised dedicated input
  input wire index_in, // Synchronised encoder index
  input wire [31:0] position, // Actual position to latch
  output reg [7:0] status_r, // Status byte
  output reg [31:0] rise_pos_r, // Rising-edge capture
  output reg [31:0] fall_pos_r // Falling-edge capture
);
  reg trig_d_r;
  reg rise_done_r;
  reg fall_done_r;
  wire enable = ctrl[`PCW_ENABLE];
  wire trig = ctrl[`PCW_SOURCE] ? index_in : dig_in;
  wire rise = trig & ~trig_d_r;
  wire fall = ~trig & trig_d_r;
  // Latches allowed unless single-shot already fired
  wire rise_ok = enable & ctrl[`PCW_RISE_EN] & (ctrl[`PCW_CONTINUOUS] | ~rise_done_r);
  wire fall_ok = enable & ctrl[`PCW_FALL_EN] & (ctrl[`PCW_CONTINUOUS] | ~fall_done_r);
  // Edge capture and status assembly
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      trig_d_r <= 1'b0;
      rise_done_r <= 1'b0;
      fall_done_r <= 1'b0;
      rise_pos_r <= 32'h00000000;
      fall_pos_r <= 32'h00000000;
      status_r <= 8'h00;
    end
    else
    begin
      trig_d_r <= trig;
      if (!enable)
      begin
        rise_done_r <= 1'b0;
        fall_done_r <= 1'b0;
      end
      else
      begin
        if (rise && rise_ok)
        begin
          rise_pos_r <= position;
          rise_done_r <= 1'b1;
        end
        if (fall && fall_ok)
        begin
          fall_pos_r <= position;
          fall_done_r <= 1'b1;
        end
      end
      status_r <= 8'h00;
      status_r[`PSW_ENABLE] <= enable;
      status_r[`PSW_RISE_STORED] <= enable & (rise_done_r | (rise & rise_ok));
      status_r[`PSW_FALL_STORED] <= enable & (fall_done_r | (fall & fall_ok));
      status_r[`PSW_SOURCE] <= ctrl[`PCW_SOURCE];
      status_r[`PSW_LEVEL] <= trig;
    end
  end
endmodule // probe_unit
`default_nettype wire

// ### tb/mspp_chk.sv
// Checker of the motion parameter bank: timing relations seen at the top ports.
// Assumes the bank header is on the include path; attached to the top module by bind.
`default_nettype none
`include "motion_params_regs.vh"
module mspp_chk (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic [15:0] rd_index, // Read index
  input wire logic rd_valid_r, // Read mapped
  input wire logic [2:0] op_mode, // Mode
  input wire logic homing_enable, // Homing start
  input wire logic halt, // Halt request
  input wire logic [2:0] halt_option, // Halt option
  input wire logic decel_point_hit, // Decel point
  input wire logic decel_done, // Ramp done
  input wire logic home_qual_r, // Qualified home
  input wire logic [1:0] speed_ff_src, // Speed ff source
  input wire logic [1:0] torque_ff_src, // Torque ff source
  input wire logic [31:0] target_position, // Target position
  input wire logic [31:0] eff_position_r, // Effective position
  input wire logic speed_ff_valid_r, // Speed ff used
  input wire logic torque_ff_valid_r, // Torque ff used
  input wire logic halt_decel_r, // Halt ramp
  input wire logic [31:0] active_accel_r // Accel in effect
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helper terms
  // ****************************************
  wire logic hold_w = (op_mode == `MODE_HOMING) && halt && (halt_option == `HALT_OPT_HOMING_ACCEL);
  wire logic spd_w = (op_mode == `MODE_POS) && (speed_ff_src == `FF_SRC_BUS);
  wire logic trq_w = (op_mode == `MODE_POS) && (torque_ff_src == `FF_SRC_BUS);
  wire logic known_w = rd_index inside {`IDX_HOMING_ACCEL, `IDX_POSITION_OFFSET,
    `IDX_VELOCITY_OFFSET, `IDX_TORQUE_OFFSET, `IDX_PROBE_CONTROL, `IDX_PROBE_STATUS};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ****************************************
  // Properties
  // ****************************************
  sequence s_decel;
    (op_mode == `MODE_HOMING) && homing_enable && decel_point_hit && !decel_done ##1 !decel_done;
  endsequence
  sequence s_idle_enable;
    !homing_enable ##1 !homing_enable;
  endsequence
  property p_freeze; s_decel |=> $stable(home_qual_r); endproperty
  property p_halt; 1'b1 |=> halt_decel_r == $past(hold_w); endproperty
  property p_pos; (op_mode != `MODE_POS) |=> eff_position_r == $past(target_position); endproperty
  property p_spd; 1'b1 |=> speed_ff_valid_r == $past(spd_w); endproperty
  property p_trq; trq_w |=> torque_ff_valid_r; endproperty
  property p_accel_hold; s_idle_enable |=> $stable(active_accel_r); endproperty
  property p_accel_nz; active_accel_r != 32'h00000000; endproperty
  property p_rd_valid; rd_index != `IDX_HOMING_SPEEDS |=> rd_valid_r == $past(known_w); endproperty
  a_freeze: assert property (p_freeze)
    else $error("home input changed during ramp-down");
  a_halt: assert property (p_halt)
    else $error("halt ramp flag wrong");
  a_pos: assert property (p_pos)
    else $error("position offset applied outside position mode");
  a_spd: assert property (p_spd)
    else $error("speed feedforward use wrong");
  a_trq: assert property (p_trq)
    else $error("torque feedforward not used");
  a_accel_hold: assert property (p_accel_hold)
    else $error("accel changed without homing enable");
  a_accel_nz: assert property (p_accel_nz)
    else $error("accel in effect is zero");
  a_rd_valid: assert property (p_rd_valid)
    else $error("read valid wrong");
endmodule // mspp_chk
bind motion_setpoint_probe_params mspp_chk chk (.clk(clk), .rstn(rstn), .rd_index(rd_index),
  .rd_valid_r(rd_valid_r), .op_mode(op_mode), .homing_enable(homing_enable), .halt(halt),
  .halt_option(halt_option), .decel_point_hit(decel_point_hit), .decel_done(decel_done),
  .home_qual_r(home_qual_r), .speed_ff_src(speed_ff_src), .torque_ff_src(torque_ff_src),
  .target_position(target_position), .eff_position_r(eff_position_r),
  .speed_ff_valid_r(speed_ff_valid_r), .torque_ff_valid_r(torque_ff_valid_r),
  .halt_decel_r(halt_decel_r), .active_accel_r(active_accel_r));
`default_nettype wire

// ### tb/fieldbus_master_model.sv
// Fieldbus master stand-in: writes objects with one-cycle strobes.
// Assumes the bank samples its write port on the rising edge of clk.
`default_nettype none
module fieldbus_master_model (
  input wire logic clk, // Clock
  output logic obj_wr = 1'b0, // Write strobe
  output logic [15:0] obj_index = 16'h0000, // Object index
  output logic [7:0] obj_sub = 8'h00, // Sub-index
  output logic [31:0] obj_wdata = 32'h00000000 // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // One write; afterwards the idle lines show the inverse so stale data cannot pass
  task automatic put(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    @(posedge clk);
    #1;
    obj_wr = 1'b1;
    obj_index = idx;
    obj_sub = sub;
    obj_wdata = d;
    @(posedge clk);
    #1;
    obj_wr = 1'b0;
    obj_index = ~idx;
    obj_sub = ~sub;
    obj_wdata = ~d;
  endtask
endmodule // fieldbus_master_model
`default_nettype wire

// ### tb/motion_setpoint_probe_params_bench.sv
// Self-checking bench of the motion parameter bank.
// Assumes the bank header on the include path; writes come from the master model.
`default_nettype none
`include "motion_params_regs.vh"
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      err_count++; \
      $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module motion_setpoint_probe_params_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, homing_enable = 1'b0, halt = 1'b0, decel_point_hit = 1'b0;
  logic decel_done = 1'b0, home_in = 1'b0, probe_one_input = 1'b0, probe_two_input = 1'b0;
  logic encoder_index = 1'b0, obj_wr, rd_valid_r, speed_ff_valid_r, torque_ff_valid_r;
  logic home_qual_r, halt_decel_r;
  logic [1:0] speed_ff_src = 2'h0, torque_ff_src = 2'h0;
  logic [2:0] op_mode = 3'h0, halt_option = 3'h0;
  logic [7:0] obj_sub, rd_sub = 8'h00;
  logic [15:0] rd_index = 16'h0000, target_torque = 16'h0000;
  logic [15:0] obj_index, eff_torque_r, torque_ff_r, probe_status_r;
  logic [31:0] target_position = 32'h0, target_velocity = 32'h0, actual_position = 32'h0;
  logic [31:0] obj_wdata, rd_data_r, eff_position_r, eff_velocity_r, speed_ff_r;
  logic [31:0] homing_speed_r, active_accel_r;
  logic [31:0] probe1_rise_pos_r, probe1_fall_pos_r, probe2_rise_pos_r, probe2_fall_pos_r;
  int err_count = 0, check_count = 0, cycles = 0;
  fieldbus_master_model master (.clk(clk), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_sub(obj_sub), .obj_wdata(obj_wdata));
  motion_setpoint_probe_params dut (.clk(clk), .rstn(rstn), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .rd_index(rd_index),
    .rd_sub(rd_sub), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .op_mode(op_mode),
    .homing_enable(homing_enable), .halt(halt), .halt_option(halt_option),
    .decel_point_hit(decel_point_hit), .decel_done(decel_done), .home_in(home_in),
    .speed_ff_src(speed_ff_src), .torque_ff_src(torque_ff_src),
    .target_position(target_position), .target_velocity(target_velocity),
    .target_torque(target_torque), .actual_position(actual_position),
    .probe_one_input(probe_one_input), .probe_two_input(probe_two_input),
    .encoder_index(encoder_index), .eff_position_r(eff_position_r),
    .eff_velocity_r(eff_velocity_r), .eff_torque_r(eff_torque_r), .speed_ff_r(speed_ff_r),
    .speed_ff_valid_r(speed_ff_valid_r), .torque_ff_r(torque_ff_r),
    .torque_ff_valid_r(torque_ff_valid_r), .homing_speed_r(homing_speed_r),
    .active_accel_r(active_accel_r), .home_qual_r(home_qual_r), .halt_decel_r(halt_decel_r),
    .probe_status_r(probe_status_r), .probe1_rise_pos_r(probe1_rise_pos_r),
    .probe1_fall_pos_r(probe1_fall_pos_r), .probe2_rise_pos_r(probe2_rise_pos_r),
    .probe2_fall_pos_r(probe2_fall_pos_r));
  // ****************************************
  // Clock, timeout and closing
  // ****************************************
  always #25 clk = ~clk;
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Advance n edges, landing just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    rd_index = idx;
    rd_sub = sub;
    step(2);
    `CHK(rd_data_r, exp)
    `CHK(rd_valid_r, 1'b1)
  endtask
  // Index pulse wide enough for the pin filter, position held through both edges
  task automatic pulse_index(input logic [31:0] pos);
    actual_position = pos;
    encoder_index = 1'b1;
    step(8);
    encoder_index = 1'b0;
    step(8);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(homing_speed_r, 32'h001AAAAB)
    `CHK(active_accel_r, 32'h00000064)
    rd_chk(`IDX_HOMING_SPEEDS, `SUB_SWITCH_SPEED, 32'h001AAAAB);
    rd_chk(`IDX_HOMING_SPEEDS, `SUB_ZERO_SPEED, 32'h00000064);
    rd_chk(`IDX_HOMING_ACCEL, 8'h00, 32'h00000064);
    rd_chk(`IDX_POSITION_OFFSET, 8'h00, 32'h00000000);
    rd_chk(`IDX_VELOCITY_OFFSET, 8'h00, 32'h00000000);
    rd_chk(`IDX_TORQUE_OFFSET, 8'h00, 32'h00000000);
    rd_chk(`IDX_PROBE_CONTROL, 8'h00, 32'h00000000);
    rd_index = 16'h1234;
    step(2);
    `CHK(rd_valid_r, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_homing();
    master.put(`IDX_HOMING_SPEEDS, `SUB_SWITCH_SPEED, 32'hFFFFFFFF);
    master.put(`IDX_HOMING_SPEEDS, `SUB_ZERO_SPEED, 32'h00000009);
    rd_chk(`IDX_HOMING_SPEEDS, `SUB_ZERO_SPEED, 32'h00000064);
    master.put(`IDX_HOMING_SPEEDS, `SUB_ZERO_SPEED, 32'h0000000A);
    rd_chk(`IDX_HOMING_SPEEDS, `SUB_ZERO_SPEED, 32'h0000000A);
    rd_chk(`IDX_HOMING_SPEEDS, `SUB_SWITCH_SPEED, 32'hFFFFFFFF);
    master.put(`IDX_HOMING_ACCEL, 8'h00, 32'h00000000);
    rd_chk(`IDX_HOMING_ACCEL, 8'h00, 32'h00000001);
    master.put(`IDX_HOMING_ACCEL, 8'h00, 32'h00000500);
    step(3);
    `CHK(active_accel_r, 32'h00000064)
    op_mode = `MODE_HOMING;
    halt = 1'b1;
    halt_option = 3'h2;
    homing_enable = 1'b1;
    step(2);
    `CHK(active_accel_r, 32'h00000500)
    `CHK(halt_decel_r, 1'b1)
    halt_option = 3'h3;
    step(2);
    `CHK(halt_decel_r, 1'b0)
    halt = 1'b0;
    `CHK(homing_speed_r, 32'hFFFFFFFF)
    decel_point_hit = 1'b1;
    step(1);
    decel_point_hit = 1'b0;
    home_in = 1'b1;
    step(4);
    `CHK(home_qual_r, 1'b0)
    `CHK(homing_speed_r, 32'h0000000A)
    decel_done = 1'b1;
    step(1);
    decel_done = 1'b0;
    step(2);
    `CHK(home_qual_r, 1'b1)
    homing_enable = 1'b0;
    $display("test homing done");
  endtask
  task automatic t_offsets();
    op_mode = `MODE_POS;
    target_position = 32'h00000064;
    speed_ff_src = 2'h2;
    torque_ff_src = 2'h1;
    master.put(`IDX_POSITION_OFFSET, 8'h00, 32'hFFFFFFFB);
    master.put(`IDX_VELOCITY_OFFSET, 8'h00, 32'h00000007);
    master.put(`IDX_TORQUE_OFFSET, 8'h00, 32'h00001770);
    step(2);
    `CHK(eff_position_r, 32'h0000005F)
    `CHK(speed_ff_r, 32'h00000007)
    `CHK(speed_ff_valid_r, 1'b1)
    `CHK(torque_ff_valid_r, 1'b0)
    rd_chk(`IDX_TORQUE_OFFSET, 8'h00, 32'h00001388);
    master.put(`IDX_TORQUE_OFFSET, 8'h00, 32'hFFFFE890);
    rd_chk(`IDX_TORQUE_OFFSET, 8'h00, 32'hFFFFEC78);
    torque_ff_src = 2'h2;
    speed_ff_src = 2'h1;
    step(2);
    `CHK(torque_ff_r, 16'hEC78)
    `CHK(torque_ff_valid_r, 1'b1)
    `CHK(speed_ff_valid_r, 1'b0)
    op_mode = `MODE_VEL;
    target_velocity = 32'h000003E8;
    step(2);
    `CHK(eff_velocity_r, 32'h000003EF)
    `CHK(eff_position_r, 32'h00000064)
    op_mode = `MODE_TRQ;
    target_torque = 16'h1400;
    step(2);
    `CHK(eff_torque_r, 16'h0078)
    $display("test offsets done");
  endtask
  task automatic t_probe();
    master.put(`IDX_PROBE_CONTROL, 8'h00, 32'h00000011);
    actual_position = 32'h00000111;
    probe_one_input = 1'b1;
    step(8);
    `CHK(probe1_rise_pos_r, 32'h00000111)
    `CHK(probe_status_r[7:0], 8'h83)
    actual_position = 32'h00000222;
    probe_one_input = 1'b0;
    step(8);
    `CHK(probe_status_r[7:0], 8'h03)
    `CHK(probe1_fall_pos_r, 32'h00000000)
    probe_one_input = 1'b1;
    step(8);
    `CHK(probe1_rise_pos_r, 32'h00000111)
    probe_one_input = 1'b0;
    master.put(`IDX_PROBE_CONTROL, 8'h00, 32'h00003700);
    master.put(`IDX_PROBE_STATUS, 8'h00, 32'h0000FFFF);
    step(8);
    `CHK(probe_status_r[7:0], 8'h00)
    pulse_index(32'h00000333);
    `CHK(probe2_fall_pos_r, 32'h00000333)
    pulse_index(32'h00000444);
    `CHK(probe2_rise_pos_r, 32'h00000444)
    `CHK(probe2_fall_pos_r, 32'h00000444)
    actual_position = 32'h00000555;
    probe_two_input = 1'b1;
    step(8);
    probe_two_input = 1'b0;
    step(8);
    `CHK(probe2_rise_pos_r, 32'h00000444)
    `CHK(probe_status_r, 16'h4700)
    rd_chk(`IDX_PROBE_STATUS, 8'h00, 32'h00004700);
    $display("test probe done");
  endtask
  // Reset for 12 cycles, then run the scenarios
  initial
  begin
    step(12);
    rstn = 1'b1;
    t_reset();
    t_homing();
    t_offsets();
    t_probe();
    give_verdict();
  end
endmodule // motion_setpoint_probe_params_bench
`default_nettype wire
